// ==== logic/xbi_pkg.sv ====
// constants and types shared by the external bus interface files
// assumes a single machine clock domain and a synchronous active-low reset
package xbi_pkg;

  // bus widths
  localparam int unsigned ADDR_W     = 23;
  localparam int unsigned LOW_ADDR_W = 16;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned WS_W       = 3;

  // ready is honoured only from this many software wait states upward
  localparam logic [2:0] WS_READY_MIN = 3'h2;

  // clock output divider select: code n divides the machine clock by n+1
  localparam logic [1:0] CLKDIV_BY1 = 2'h0;
  localparam logic [1:0] CLKDIV_RST = 2'h3;

  // space codes presented by the core with each request
  localparam logic [1:0] SPACE_PROG = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_IO   = 2'h2;

  // on-chip rom occupies the upper 16K words: A15..A14 both set
  localparam logic [1:0] ROM_PAGE_BITS = 2'h3;

  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // bus sequencer states
  typedef enum logic [2:0] {
    XBI_IDLE,
    XBI_ACCESS,
    XBI_READY_WAIT,
    XBI_HOLD,
    XBI_RELEASE
  } xbi_state_t;

endpackage

// ==== logic/xbi_pin_sync.sv ====
// three-flop synchroniser for pins arriving from outside the clock domain
// assumes the pin may change at any time; out of reset the output moves only once the
// second and third stages agree, so a one-cycle glitch is not passed on
`timescale 1ns/1ps
`default_nettype none

module xbi_pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pin side and synchronised level
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);
  wire  [W-1:0] level_d = (agree & s3_q) | (~agree & level_q);

  // stage one feeds stage two only, never any other logic; the stages are
  // not reset, so a strap pin has already settled when reset is released
  always_ff @(posedge clk) begin
    s1_q <= pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // in reset the level tracks stage two, so straps are seen before release
  always_ff @(posedge clk) begin
    if (!rst_n)
      level_q <= s2_q;
    else
      level_q <= level_d;
  end

  assign level = level_q;

endmodule

`default_nettype wire

// ==== logic/xbi_bus_if.sv ====
// external parallel bus interface: space selects, strobes, wait states,
// hold handover, fetch and interrupt-acknowledge marking, clock output
// assumes the core side runs on REF_CLK and keeps a request steady until
// CORE_ACK; all pins leave through tri-state pads driven from *_OE
`timescale 1ns/1ps
`default_nettype none

// How it works
// - a space select idles high, low only while its access is addressed
// - in hold, selects, strobes and direction are released
// - memory strobe goes low only for program or data accesses
// - io strobe goes low only for io accesses
// - direction stays high except during an external write
// - ready low stretches the access; it is checked again every cycle
// - ready is honoured only with two or more wait states, after them
// - with two or more wait states, microstate-done is low in the last
// - a hold request is granted in the same cycle as the bus lines are released
// - hold acknowledge shows only while the bus is actually released
// - fetch marker is low while a fetch address is on the bus
// - interrupt acknowledge is low while the vector fetch is on the bus
// - clock output divides by 1 to 4, divide-by-4 after reset
// - output-disable releases every control and status pin
// - boot select low at reset maps the rom into the upper 16K
// - data bus driven only during writes, never in reset or hold
// - upper address lines carry only program addresses
module xbi_bus_if #(
  parameter int unsigned WS_W_P = xbi_pkg::WS_W
) (
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RESETN,
  // core request side
  input  wire logic                       CORE_REQ,
  input  wire logic [1:0]                 CORE_SPACE,
  input  wire logic                       CORE_WRITE,
  input  wire logic                       CORE_FETCH,
  input  wire logic                       CORE_VECTOR,
  input  wire logic [xbi_pkg::ADDR_W-1:0] CORE_ADDR,
  input  wire logic [xbi_pkg::DATA_W-1:0] CORE_WDATA,
  input  wire logic [WS_W_P-1:0]          CORE_WAIT_STATES,
  output logic                            CORE_GRANT,
  output logic                            CORE_ACK,
  output logic                            CORE_ROM_HIT,
  output logic [xbi_pkg::DATA_W-1:0]      CORE_RDATA,
  // bank switch control field write
  input  wire logic                       CORE_BANK_SWITCH_CTRL_REG_WR,
  input  wire logic [1:0]                 CORE_BANK_SWITCH_CTRL_REG_CLKDIV,
  input  wire logic                       CORE_BANK_SWITCH_CTRL_REG_HOLDER,
  output logic                            ROM_MAPPED,
  // address and data pins
  output logic [xbi_pkg::ADDR_W-1:0]      ADDR_O,
  output logic                            ADDR_OE,
  input  wire logic [xbi_pkg::DATA_W-1:0] DATA_I,
  output logic [xbi_pkg::DATA_W-1:0]      DATA_O,
  output logic                            DATA_OE,
  output logic                            DATA_HOLDER_EN,
  // bus control pins, enabled by CTRL_OE
  output logic                            PROGRAM_SPACE_SELECT_N,
  output logic                            DATA_SPACE_SELECT_N,
  output logic                            IO_SPACE_SELECT_N,
  output logic                            MEMORY_STROBE_N,
  output logic                            IO_STROBE_N,
  output logic                            READ_WRITE_N,
  output logic                            CTRL_OE,
  // status pins, enabled by STATUS_OE
  output logic                            MICROSTATE_DONE_N,
  output logic                            HOLD_ACK_N,
  output logic                            INSTR_FETCH_N,
  output logic                            IRQ_ACK_N,
  output logic                            MACHINE_CLOCK_OUT,
  output logic                            STATUS_OE,
  // pins from outside the clock domain
  input  wire logic                       READY,
  input  wire logic                       HOLD_REQ_N,
  input  wire logic                       BOOT_ROM_MAP_SEL,
  input  wire logic                       TEST_RESET,
  input  wire logic                       EMU_PIN_ZERO,
  input  wire logic                       EMU_PIN_ONE_TRISTATE_N
);

  // refuse a wait state counter the ready threshold cannot live in
  if (WS_W_P < 2 || WS_W_P > 8) begin : g_ws_w_check
    $error("wait state width must lie between 2 and 8");
  end

  // synchronised pin levels
  logic [5:0] pins_s;
  logic       ready_s;
  logic       hold_req_s;
  logic       boot_sel_s;
  logic       off_s;

  xbi_pin_sync #(
    .W (6)
  ) u_pin_sync (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .pin   ({READY, ~HOLD_REQ_N, BOOT_ROM_MAP_SEL, ~TEST_RESET,
             EMU_PIN_ZERO, ~EMU_PIN_ONE_TRISTATE_N}),
    .level (pins_s)
  );

  assign ready_s    = pins_s[5];
  assign hold_req_s = pins_s[4];
  assign boot_sel_s = pins_s[3];
  // output disable only with test reset low, emu zero high, emu one low
  assign off_s      = pins_s[2] & pins_s[1] & pins_s[0];

  // sequencer and access state
  xbi_pkg::xbi_state_t          state_q, state_d;
  logic [1:0]                   space_q;
  logic                         write_q;
  logic                         fetch_q;
  logic                         vector_q;
  logic [xbi_pkg::ADDR_W-1:0]   addr_q;
  logic [xbi_pkg::DATA_W-1:0]   wdata_q;
  logic [xbi_pkg::DATA_W-1:0]   rdata_q;
  logic [WS_W_P-1:0]            ws_total_q;
  logic [WS_W_P-1:0]            ws_left_q;
  logic                         ack_q;
  logic                         rom_hit_q;
  logic                         rom_map_q;
  logic                         holder_q;
  logic [1:0]                   clkdiv_q;
  logic [1:0]                   clkcnt_q;
  logic                         clk_div_q;

  // request decode
  wire in_access  = (state_q == xbi_pkg::XBI_ACCESS) ||
                    (state_q == xbi_pkg::XBI_READY_WAIT);
  wire released   = (state_q == xbi_pkg::XBI_HOLD) ||
                    (state_q == xbi_pkg::XBI_RELEASE);
  wire prog_req   = CORE_SPACE == xbi_pkg::SPACE_PROG;
  wire rom_target = rom_map_q && prog_req &&
                    CORE_ADDR[15:14] == xbi_pkg::ROM_PAGE_BITS;
  wire take_req   = CORE_GRANT && CORE_REQ;
  wire ready_used = ws_total_q >= WS_W_P'(xbi_pkg::WS_READY_MIN);
  wire ws_done    = ws_left_q == '0;
  // ready low holds the access for one more cycle, then is looked at again
  wire finish     = (state_q == xbi_pkg::XBI_ACCESS && ws_done &&
                     !ready_used) ||
                    (state_q == xbi_pkg::XBI_READY_WAIT && ready_s);

  // hold wins over a new request, and only between bus cycles
  assign CORE_GRANT = (state_q == xbi_pkg::XBI_IDLE) && !hold_req_s;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      xbi_pkg::XBI_IDLE: begin
        if (hold_req_s)
          state_d = xbi_pkg::XBI_HOLD;
        else if (take_req && !rom_target)
          state_d = xbi_pkg::XBI_ACCESS;
      end
      xbi_pkg::XBI_ACCESS: begin
        if (ws_done && ready_used)
          state_d = xbi_pkg::XBI_READY_WAIT;
        else if (ws_done)
          state_d = xbi_pkg::XBI_IDLE;
      end
      xbi_pkg::XBI_READY_WAIT: begin
        if (ready_s)
          state_d = xbi_pkg::XBI_IDLE;
      end
      xbi_pkg::XBI_HOLD: begin
        if (!hold_req_s)
          state_d = xbi_pkg::XBI_RELEASE;
      end
      xbi_pkg::XBI_RELEASE: begin
        state_d = xbi_pkg::XBI_IDLE;
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge REF_CLK) begin
    if (!RESETN)
      state_q <= xbi_pkg::XBI_IDLE;
    else
      state_q <= state_d;
  end

  // latch the request; upper address lines are zero outside program space
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      space_q    <= xbi_pkg::SPACE_PROG;
      write_q    <= 1'b0;
      fetch_q    <= 1'b0;
      vector_q   <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
      ws_total_q <= '0;
    end else if (take_req && !rom_target) begin
      space_q    <= CORE_SPACE;
      write_q    <= CORE_WRITE;
      fetch_q    <= CORE_FETCH;
      vector_q   <= CORE_VECTOR;
      addr_q     <= prog_req ? CORE_ADDR :
                    {{(xbi_pkg::ADDR_W-xbi_pkg::LOW_ADDR_W){1'b0}},
                     CORE_ADDR[xbi_pkg::LOW_ADDR_W-1:0]};
      wdata_q    <= CORE_WDATA;
      ws_total_q <= CORE_WAIT_STATES;
    end
  end

  // software wait state countdown
  always_ff @(posedge REF_CLK) begin
    if (!RESETN)
      ws_left_q <= '0;
    else if (take_req)
      ws_left_q <= CORE_WAIT_STATES;
    else if (state_q == xbi_pkg::XBI_ACCESS && !ws_done)
      ws_left_q <= ws_left_q - WS_W_P'(1);
  end

  // completion pulse and read capture at the last access cycle
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ack_q     <= 1'b0;
      rom_hit_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      ack_q     <= finish || (take_req && rom_target);
      rom_hit_q <= take_req && rom_target;
      if (finish && !write_q)
        rdata_q <= DATA_I;
    end
  end

  // boot select follows the pin throughout reset, frozen at release
  always_ff @(posedge REF_CLK) begin
    if (!RESETN)
      rom_map_q <= !boot_sel_s;
  end

  // bank switch fields: divider select and data bus holder
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      clkdiv_q <= xbi_pkg::CLKDIV_RST;
      holder_q <= 1'b0;
    end else if (CORE_BANK_SWITCH_CTRL_REG_WR) begin
      clkdiv_q <= CORE_BANK_SWITCH_CTRL_REG_CLKDIV;
      holder_q <= CORE_BANK_SWITCH_CTRL_REG_HOLDER;
    end
  end

  // clock divider: high for the first half of each divided period
  wire [1:0] clkcnt_d = (clkcnt_q >= clkdiv_q) ? 2'h0 : clkcnt_q + 2'h1;
  wire [1:0] half     = 2'((3'(clkdiv_q) + 3'h2) >> 1);

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      clkcnt_q  <= 2'h0;
      clk_div_q <= 1'b1;
    end else begin
      clkcnt_q  <= clkcnt_d;
      clk_div_q <= clkcnt_d < half;
    end
  end

  // divide-by-one cannot come from a flop, so the clock itself is muxed out
  assign MACHINE_CLOCK_OUT = (clkdiv_q == xbi_pkg::CLKDIV_BY1) ?
                             REF_CLK : clk_div_q;

  // space selects and strobes are low only while the access is addressed
  wire acc_prog = in_access && space_q == xbi_pkg::SPACE_PROG;
  wire acc_data = in_access && space_q == xbi_pkg::SPACE_DATA;
  wire acc_io   = in_access && space_q == xbi_pkg::SPACE_IO;

  assign PROGRAM_SPACE_SELECT_N = !acc_prog;
  assign DATA_SPACE_SELECT_N    = !acc_data;
  assign IO_SPACE_SELECT_N      = !acc_io;
  assign MEMORY_STROBE_N        = !(acc_prog || acc_data);
  assign IO_STROBE_N            = !acc_io;
  assign READ_WRITE_N           = !(in_access && write_q);

  // control pins float in hold or under output disable
  assign CTRL_OE = !released && !off_s;
  assign ADDR_OE = !released && !off_s;
  assign ADDR_O  = addr_q;

  // data bus: driven only during a write access
  assign DATA_OE        = in_access && write_q && !off_s && RESETN;
  assign DATA_O         = wdata_q;
  assign DATA_HOLDER_EN = holder_q;

  // status pins; the release cycle keeps the bus off with ack already high
  assign MICROSTATE_DONE_N = !(state_q == xbi_pkg::XBI_ACCESS && ready_used &&
                               ws_done);
  assign HOLD_ACK_N    = state_q != xbi_pkg::XBI_HOLD;
  assign INSTR_FETCH_N = !(in_access && fetch_q);
  assign IRQ_ACK_N     = !(in_access && vector_q);
  assign STATUS_OE     = !off_s;

  // core answer
  assign CORE_ACK     = ack_q;
  assign CORE_ROM_HIT = rom_hit_q;
  assign CORE_RDATA   = rdata_q;
  assign ROM_MAPPED   = rom_map_q;

endmodule

`default_nettype wire

// ==== logic/xbi_pkg_note_unused.sv ====
// no content: kept empty deliberately
`default_nettype none
`default_nettype wire

// ==== bench/xbi_chk.sv ====
// assertions on the external bus interface ports
// assumes a bind from the bench top file; one clock domain
`timescale 1ns/1ps
`default_nettype none
module xbi_chk #(
  parameter int unsigned WS_W_P = 3
) (
  // clock, reset and core side
  input wire logic              REF_CLK,
  input wire logic              RESETN,
  input wire logic              CORE_REQ,
  input wire logic              CORE_GRANT,
  input wire logic              CORE_ACK,
  input wire logic              CORE_ROM_HIT,
  input wire logic [WS_W_P-1:0] CORE_WAIT_STATES,
  // bus pins
  input wire logic              ADDR_OE,
  input wire logic              DATA_OE,
  input wire logic              CTRL_OE,
  input wire logic              PROGRAM_SPACE_SELECT_N,
  input wire logic              DATA_SPACE_SELECT_N,
  input wire logic              IO_SPACE_SELECT_N,
  input wire logic              MEMORY_STROBE_N,
  input wire logic              IO_STROBE_N,
  input wire logic              READ_WRITE_N,
  input wire logic              MICROSTATE_DONE_N,
  input wire logic              HOLD_ACK_N
);
  logic [4:0]        cnt_q;
  logic [WS_W_P-1:0] ws_q;
  wire               sel = !(PROGRAM_SPACE_SELECT_N && DATA_SPACE_SELECT_N
                             && IO_SPACE_SELECT_N);
  wire               strb = !(MEMORY_STROBE_N && IO_STROBE_N);
  // cycles since a request was taken; saturates so long stalls stay legal
  always_ff @(posedge REF_CLK) begin
    if (!RESETN || (CORE_REQ && CORE_GRANT)) begin
      cnt_q <= RESETN ? 5'h01 : 5'h1F;
      ws_q  <= CORE_WAIT_STATES;
    end else if (cnt_q != 5'h1F) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  a_sel_addr: assert property (sel |-> ADDR_OE && HOLD_ACK_N)
    else $error("select low without driven address");
  a_mem_strobe: assert property (
    !MEMORY_STROBE_N |-> IO_SPACE_SELECT_N && sel)
    else $error("memory strobe outside a memory access");
  a_io_strobe: assert property (!IO_STROBE_N |-> !IO_SPACE_SELECT_N)
    else $error("io strobe outside an io access");
  a_write_dir: assert property (
    DATA_OE |-> !READ_WRITE_N && strb)
    else $error("data driven outside a write");
  a_hold_float: assert property (
    !HOLD_ACK_N |-> !CTRL_OE && !ADDR_OE && !DATA_OE)
    else $error("bus driven while hold acknowledged");
  // the cycle before the grant must have had no access on the bus
  a_hold_edge: assert property (
    $fell(HOLD_ACK_N) |-> !$past(sel) && !$past(strb))
    else $error("hold granted inside an access");
  a_rel_gap: assert property (
    $rose(HOLD_ACK_N) |-> !CTRL_OE ##1 CTRL_OE)
    else $error("bus driven before hold release cycle");
  // with ready in use, one cycle samples ready after the last wait state
  a_ack_time: assert property (
    CORE_ACK && !CORE_ROM_HIT |-> ((ws_q < 2) ?
    cnt_q == 5'(ws_q) + 5'h02 : cnt_q >= 5'(ws_q) + 5'h03))
    else $error("access ended at wrong cycle");
  a_msc_last: assert property (
    !MICROSTATE_DONE_N |-> ws_q >= 2 && cnt_q == 5'(ws_q) + 5'h01)
    else $error("microstate done outside last wait state");
  c_hold: cover property ($fell(HOLD_ACK_N));
  c_msc: cover property (!MICROSTATE_DONE_N);
  c_rom: cover property (CORE_ACK && CORE_ROM_HIT);
endmodule
`default_nettype wire

// ==== bench/xbi_mem_model.sv ====
// far-side memory and io model, 16 words, ready held low for a stall
// assumes the bench sets the stall; zero answers at once
`timescale 1ns/1ps
`default_nettype none
module xbi_mem_model (
  // clock and bus pins
  input  wire logic        REF_CLK,
  input  wire logic [22:0] ADDR_O,
  input  wire logic [15:0] DATA_O,
  input  wire logic        MEMORY_STROBE_N,
  input  wire logic        IO_STROBE_N,
  input  wire logic        READ_WRITE_N,
  // stall length in strobe cycles
  input  wire logic [4:0]  stall,
  // answer pins
  output logic      [15:0] DATA_I,
  output logic             READY
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0000;
  logic [4:0]  cnt_q = 5'h00;
  wire         strb = !(MEMORY_STROBE_N && IO_STROBE_N);
  // store writes and count strobe cycles for the stall
  always @(posedge REF_CLK) begin
    cnt_q <= strb ? cnt_q + 5'h01 : 5'h00;
    if (strb && !READ_WRITE_N) mem[ADDR_O[3:0]] <= DATA_O;
    if (strb && READ_WRITE_N) last_q <= mem[ADDR_O[3:0]];
  end
  // released bus shows the inverse, so a stale read never looks right
  assign READY  = cnt_q >= stall;
  assign DATA_I = (strb && READ_WRITE_N) ? mem[ADDR_O[3:0]] : ~last_q;
endmodule
`default_nettype wire

// ==== bench/xbi_bus_if_tb.sv ====
// bench for the external bus interface: accesses, waits, hold, clock out
// assumes the far-side model below and the checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module xbi_bus_if_tb;
  logic        REF_CLK = 1'b0, RESETN = 1'b0, CORE_REQ = 1'b0;
  logic [1:0]  CORE_SPACE = 2'h0, CORE_BANK_SWITCH_CTRL_REG_CLKDIV = 2'h0;
  logic        CORE_WRITE = 1'b0, CORE_FETCH = 1'b0, CORE_VECTOR = 1'b0;
  logic [22:0] CORE_ADDR = 23'h000000, ADDR_O;
  logic [15:0] CORE_WDATA = 16'h0000, CORE_RDATA, DATA_I, DATA_O, rd;
  logic [2:0]  CORE_WAIT_STATES = 3'h0;
  logic        CORE_BANK_SWITCH_CTRL_REG_WR = 1'b0, CORE_BANK_SWITCH_CTRL_REG_HOLDER = 1'b0, READY;
  logic        HOLD_REQ_N = 1'b1, BOOT_ROM_MAP_SEL = 1'b1, TEST_RESET = 1'b0;
  logic        EMU_PIN_ZERO = 1'b1, EMU_PIN_ONE_TRISTATE_N = 1'b1;
  logic        CORE_GRANT, CORE_ACK, CORE_ROM_HIT, ROM_MAPPED, ADDR_OE;
  logic        DATA_OE, DATA_HOLDER_EN, PROGRAM_SPACE_SELECT_N, CTRL_OE;
  logic        DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N, MEMORY_STROBE_N;
  logic        IO_STROBE_N, READ_WRITE_N, MICROSTATE_DONE_N, STATUS_OE;
  logic        HOLD_ACK_N, INSTR_FETCH_N, IRQ_ACK_N, MACHINE_CLOCK_OUT;
  logic [4:0]  stall = 5'h00;
  logic        hit;
  int          cyc, fail_count = 0, samples_checked = 0;
  wire  [2:0]  sel_n = {PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N,
                        IO_SPACE_SELECT_N};
  // clock, design and far side
  always #20 REF_CLK = ~REF_CLK;
  xbi_bus_if u_dut (.REF_CLK, .RESETN, .CORE_REQ, .CORE_SPACE, .CORE_WRITE,
    .CORE_FETCH, .CORE_VECTOR, .CORE_ADDR, .CORE_WDATA, .CORE_WAIT_STATES,
    .CORE_GRANT, .CORE_ACK, .CORE_ROM_HIT, .CORE_RDATA, .CORE_BANK_SWITCH_CTRL_REG_WR,
    .CORE_BANK_SWITCH_CTRL_REG_CLKDIV, .CORE_BANK_SWITCH_CTRL_REG_HOLDER, .ROM_MAPPED, .ADDR_O, .ADDR_OE,
    .DATA_I, .DATA_O, .DATA_OE, .DATA_HOLDER_EN, .PROGRAM_SPACE_SELECT_N,
    .DATA_SPACE_SELECT_N, .IO_SPACE_SELECT_N, .MEMORY_STROBE_N, .IO_STROBE_N,
    .READ_WRITE_N, .CTRL_OE, .MICROSTATE_DONE_N, .HOLD_ACK_N, .INSTR_FETCH_N,
    .IRQ_ACK_N, .MACHINE_CLOCK_OUT, .STATUS_OE, .READY, .HOLD_REQ_N,
    .BOOT_ROM_MAP_SEL, .TEST_RESET, .EMU_PIN_ZERO, .EMU_PIN_ONE_TRISTATE_N);
  xbi_mem_model u_mem (.REF_CLK, .ADDR_O, .DATA_O, .MEMORY_STROBE_N,
    .IO_STROBE_N, .READ_WRITE_N, .stall, .DATA_I, .READY);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic do_reset;
    RESETN = 1'b0;
    tick(4);
    RESETN = 1'b1;
  endtask
  // one access: waits for grant, checks the first bus cycle, waits for ack
  task automatic access(input logic [1:0] sp, input logic wr, fe, ve,
      input logic [22:0] a, input logic [15:0] wd, input logic [2:0] ws,
      input logic hl, output int n);
    logic rom;
    n = 0;
    while (CORE_GRANT !== 1'b1 && n < 40) begin tick(1); n++; end
    if (CORE_GRANT !== 1'b1) begin
      fail_count++;
      $display("BAD %0t no grant", $time);
      finish_test;
    end
    {CORE_SPACE, CORE_WRITE, CORE_FETCH, CORE_VECTOR, CORE_ADDR, CORE_WDATA,
     CORE_WAIT_STATES, CORE_REQ} = {sp, wr, fe, ve, a, wd, ws, 1'b1};
    rom = ROM_MAPPED && sp == 2'h0 && a[15:14] == 2'h3;
    tick(1);
    CORE_REQ = 1'b0;
    if (hl) HOLD_REQ_N = 1'b0;
    chk(sel_n, rom ? 3'h7 : 3'(~(3'h4 >> sp)));
    if (!rom) begin
      chk({MEMORY_STROBE_N, IO_STROBE_N}, sp == 2'h2 ? 2'h2 : 2'h1);
      chk({READ_WRITE_N, DATA_OE}, {!wr, wr});
      chk({INSTR_FETCH_N, IRQ_ACK_N}, {!fe, !ve});
      chk(ADDR_O, sp == 2'h0 ? a : {7'h00, a[15:0]});
    end
    n = 1;
    while (CORE_ACK !== 1'b1 && n < 60) begin tick(1); n++; end
    if (CORE_ACK !== 1'b1) begin
      fail_count++;
      $display("BAD %0t no completion", $time);
      finish_test;
    end
    rd  = CORE_RDATA;
    hit = CORE_ROM_HIT;
    // let an edge pass so the next request never lands in this time step
    tick(1);
  endtask
  task automatic clk_rises(input int exp);
    int   r;
    logic p;
    r = 0;
    p = MACHINE_CLOCK_OUT;
    repeat (12) begin
      tick(1);
      if (MACHINE_CLOCK_OUT === 1'b1 && p === 1'b0) r++;
      p = MACHINE_CLOCK_OUT;
    end
    chk(r, exp);
  endtask
  task automatic t_reset;
    chk({sel_n, MEMORY_STROBE_N, IO_STROBE_N, READ_WRITE_N, HOLD_ACK_N}, 7'h7F);
    chk({DATA_OE, ROM_MAPPED}, 2'h0);
    clk_rises(3);
    $display("test reset done");
  endtask
  task automatic t_spaces;
    for (int s = 0; s < 3; s++) begin
      access(2'(s), 1'b1, 1'b0, 1'b0, 23'h550003 + 23'(s), 16'hA5C0 + 16'(s),
             3'h0, 1'b0, cyc);
      chk(cyc, 2);
      access(2'(s), 1'b0, 1'b0, 1'b0, 23'h550003 + 23'(s), 16'h0000, 3'h1,
             1'b0, cyc);
      chk({rd, 16'(cyc)}, {16'hA5C0 + 16'(s), 16'h0003});
    end
    $display("test spaces done");
  endtask
  task automatic t_waits;
    logic [2:0] wl [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    // ready: ten strobe cycles, one model count, four edges of pin lag,
    // then the ack cycle, whatever the wait states below that
    stall = 5'h0A;
    foreach (wl[i]) begin
      access({1'b0, !i[0]}, 1'b0, i[0], i == 3, 23'h000007, 16'h0000, wl[i],
             1'b0, cyc);
      if (wl[i] < 3'h2) chk(cyc, wl[i] + 2);
      else chk(cyc, 16);
    end
    stall = 5'h00;
    $display("test waits done");
  endtask
  task automatic t_hold;
    int k;
    access(2'h2, 1'b1, 1'b0, 1'b0, 23'h000009, 16'h1234, 3'h3, 1'b1, cyc);
    // base cycle, three wait states, one ready look, then the ack cycle
    chk(cyc, 6);
    k = 0;
    while (HOLD_ACK_N !== 1'b0 && k < 8) begin tick(1); k++; end
    chk({HOLD_ACK_N, CTRL_OE, ADDR_OE, DATA_OE, CORE_GRANT}, 5'h00);
    tick(4);
    chk(HOLD_ACK_N, 1'b0);
    HOLD_REQ_N = 1'b1;
    k = 0;
    while (HOLD_ACK_N !== 1'b1 && k < 8) begin tick(1); k++; end
    chk(CTRL_OE, 1'b0);
    tick(1);
    chk({CTRL_OE, ADDR_OE, CORE_GRANT}, 3'h7);
    $display("test hold done");
  endtask
  task automatic t_clkdiv;
    for (int c = 3; c >= 0; c--) begin
      {CORE_BANK_SWITCH_CTRL_REG_CLKDIV, CORE_BANK_SWITCH_CTRL_REG_HOLDER, CORE_BANK_SWITCH_CTRL_REG_WR} = {2'(c), 2'h3};
      tick(1);
      CORE_BANK_SWITCH_CTRL_REG_WR = 1'b0;
      tick(2);
      clk_rises(c == 0 ? 0 : 12 / (c + 1));
    end
    chk(DATA_HOLDER_EN, 1'b1);
    $display("test clock done");
  endtask
  task automatic t_off;
    EMU_PIN_ONE_TRISTATE_N = 1'b0;
    EMU_PIN_ZERO = 1'b0;
    tick(6);
    chk({STATUS_OE, CTRL_OE}, 2'h3);
    EMU_PIN_ZERO = 1'b1;
    tick(6);
    chk({STATUS_OE, CTRL_OE, ADDR_OE}, 3'h0);
    TEST_RESET = 1'b1;
    tick(6);
    chk({STATUS_OE, CTRL_OE}, 2'h3);
    {TEST_RESET, EMU_PIN_ONE_TRISTATE_N} = 2'h1;
    tick(6);
    chk({STATUS_OE, CTRL_OE}, 2'h3);
    $display("test disable done");
  endtask
  task automatic t_boot;
    BOOT_ROM_MAP_SEL = 1'b0;
    do_reset;
    chk(ROM_MAPPED, 1'b1);
    access(2'h0, 1'b0, 1'b1, 1'b0, 23'h00C000, 16'h0000, 3'h0, 1'b0, cyc);
    chk({hit, 16'(cyc)}, {1'b1, 16'h0001});
    access(2'h0, 1'b0, 1'b1, 1'b0, 23'h003000, 16'h0000, 3'h0, 1'b0, cyc);
    chk({hit, 16'(cyc)}, {1'b0, 16'h0002});
    $display("test boot done");
  endtask
  initial begin
    do_reset;
    t_reset;
    t_spaces;
    t_waits;
    t_hold;
    t_clkdiv;
    t_off;
    t_boot;
    finish_test;
  end
endmodule
bind xbi_bus_if xbi_chk #(.WS_W_P(WS_W_P)) u_chk (.REF_CLK, .RESETN,
  .CORE_REQ, .CORE_GRANT, .CORE_ACK, .CORE_ROM_HIT, .CORE_WAIT_STATES,
  .ADDR_OE, .DATA_OE, .CTRL_OE, .PROGRAM_SPACE_SELECT_N, .DATA_SPACE_SELECT_N,
  .IO_SPACE_SELECT_N, .MEMORY_STROBE_N, .IO_STROBE_N, .READ_WRITE_N,
  .MICROSTATE_DONE_N, .HOLD_ACK_N);
`default_nettype wire
